// File: core/ssp_cfg.svh
/*
 * constants of the two-wire slave port: timing counts, field
 * positions and reset values.
 * assumes a 50 ns system clock; included by bare name.
 */
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSP_CLK_NS    50
`define SSP_SPIKE_NS  50
`define SSP_FILT_CYC  ((`SSP_SPIKE_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)

// ----------------------------------------------------------------
// fields and counts
// ----------------------------------------------------------------
`define SSP_LAST_BIT  4'h8
`define SSP_TX_LAST   4'h7
`define SSP_TEN_MARK  5'h1E
`define SSP_RW_POS    0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSP_BYTE_RST  8'h00
`define SSP_TX_IDLE   8'hFF
`define SSP_LINE_IDLE 1'b1

`endif

// File: core/ssp_pkg.sv
/*
 * types of the two-wire slave port: mode codes and engine states.
 * assumes nothing of its surroundings.
 */
package ssp_pkg;

    // ------------------------------------------------------------
    // mode select codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SSP_M_S7   = 4'h6,
        SSP_M_S10  = 4'h7,
        SSP_M_FWM  = 4'hB,
        SSP_M_MM7  = 4'hE,
        SSP_M_MM10 = 4'hF
    } ssp_mode_t;

    // ------------------------------------------------------------
    // engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX   = 3'h1,
        ST_ACK  = 3'h2,
        ST_TX   = 3'h3,
        ST_MACK = 3'h4
    } ssp_st_t;

endpackage : ssp_pkg

// File: core/ssp_line_if.sv
/*
 * one filtered bus line: clean level plus edge pulses.
 * assumes the filter drives it and the engine only reads it.
 */
`timescale 1ns/100ps
interface ssp_line_if;
    logic lvl;
    logic rise;
    logic fall;
    modport src (output lvl, output rise, output fall);
    modport snk (input lvl, input rise, input fall);
endinterface : ssp_line_if

// File: core/ssp_glitch_filt.sv
/*
 * synchroniser and spike filter for one bus line.
 * assumes the pin is an open-drain input sampled on clk_sys.
 */
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_glitch_filt
    import ssp_pkg::*;
#(
    parameter int FILT_CYC = `SSP_FILT_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic pin_in,
    ssp_line_if.src   line
);
    localparam int CW = $clog2(FILT_CYC + 1) + 1;

    logic          s1_r;
    logic          s2_r;
    logic          lvl_r;
    logic          rise_r;
    logic          fall_r;
    logic [CW-1:0] cnt_r;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= `SSP_LINE_IDLE;
            s2_r <= `SSP_LINE_IDLE;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
        end
    end

    // ------------------------------------------------------------
    // level must differ FILT_CYC+1 samples before it is taken
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lvl_r  <= `SSP_LINE_IDLE;
            cnt_r  <= '0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (s2_r == lvl_r) begin
                cnt_r <= '0;
            end else if (cnt_r == CW'(FILT_CYC)) begin
                cnt_r  <= '0;
                lvl_r  <= s2_r;
                rise_r <= s2_r;
                fall_r <= !s2_r;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign line.lvl  = lvl_r;
    assign line.rise = rise_r;
    assign line.fall = fall_r;

endmodule : ssp_glitch_filt

// File: core/ssp_i2c_slave.sv
/*
 * two-wire slave engine: address match, double-buffered receive,
 * clock-stretched transmit, start/stop flags.
 * assumes software strobes are one-cycle pulses on clk_sys and the
 * bus lines are open drain with external pull-ups.
 */
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_i2c_slave
    import ssp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       port_enable_bit,
    input  wire logic [3:0] mode_select_field,
    input  wire logic       buf_rd,
    input  wire logic       buf_wr,
    input  wire logic [7:0] buf_wdata,
    input  wire logic       addr_wr,
    input  wire logic [7:0] addr_wdata,
    input  wire logic       ckp_wr,
    input  wire logic       ckp_wdata,
    input  wire logic       irq_clr,
    input  wire logic       ovf_clr,
    output logic [7:0]      rx_tx_buffer,
    output logic [7:0]      slave_address_reg,
    output logic            clock_release_bit,
    output logic            buffer_full_flag,
    output logic            receive_overflow_flag,
    output logic            update_address_flag,
    output logic            serial_port_irq_flag,
    output logic            rw_flag,
    output logic            data_flag,
    output logic            start_flag,
    output logic            stop_flag
);
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic logic slave_on(input logic [3:0] m);
        slave_on = (m == SSP_M_S7) || (m == SSP_M_S10) ||
                   (m == SSP_M_MM7) || (m == SSP_M_MM10);
    endfunction : slave_on

    function automatic logic ten_bit(input logic [3:0] m);
        ten_bit = (m == SSP_M_S10) || (m == SSP_M_MM10);
    endfunction : ten_bit

    function automatic logic sp_irq(input logic [3:0] m);
        sp_irq = (m == SSP_M_FWM) || (m == SSP_M_MM7) ||
                 (m == SSP_M_MM10);
    endfunction : sp_irq

    ssp_line_if scl_l ();
    ssp_line_if sda_l ();

    ssp_st_t    st_r;
    ssp_st_t    after_r;
    logic [7:0] sr_r;
    logic [3:0] cnt_r;
    logic       in_addr_r;
    logic       hi_ok_r;
    logic       ten_hit_r;
    logic       ack_r;
    logic       ua_p_r;
    logic       mack_r;
    logic [7:0] buf_r;
    logic [7:0] sar_r;
    logic       bf_r;
    logic       ov_r;
    logic       irq_r;
    logic       ua_r;
    logic       ckp_r;
    logic       rw_r;
    logic       da_r;
    logic       start_r;
    logic       stop_r;
    logic       sda_oe_r;
    logic       scl_oe_r;
    logic       pin_lo_r;
    logic       en;
    logic       sta;
    logic       sto;
    logic       done;
    logic       nin_c;
    logic       mk_c;
    logic       tx_go;
    logic       hit_c;
    logic       rd_c;
    logic       ua_c;
    logic       hi_c;
    logic       ten_c;
    logic       load_c;
    logic       ack_c;

    // ------------------------------------------------------------
    // line filters
    // ------------------------------------------------------------
    ssp_glitch_filt u_scl_filt (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin_in  (scl_in),
        .line    (scl_l)
    );

    ssp_glitch_filt u_sda_filt (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin_in  (sda_in),
        .line    (sda_l)
    );

    // ------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------
    assign en    = port_enable_bit;
    assign sta   = scl_l.lvl && sda_l.fall;
    assign sto   = scl_l.lvl && sda_l.rise;
    assign done  = (st_r == ST_RX) && scl_l.fall && (cnt_r == `SSP_LAST_BIT);
    assign nin_c = (st_r == ST_ACK) && scl_l.fall;
    assign mk_c  = (st_r == ST_MACK) && scl_l.fall;
    assign tx_go = (nin_c && after_r == ST_TX) || (mk_c && !mack_r);

    // ------------------------------------------------------------
    // address and byte decision
    // ------------------------------------------------------------
    always_comb begin
        hit_c = 1'b0;
        rd_c  = 1'b0;
        ua_c  = 1'b0;
        hi_c  = 1'b0;
        ten_c = 1'b0;
        if (!in_addr_r) begin
            hit_c = 1'b1;
        end else if (!ten_bit(mode_select_field)) begin
            hit_c = (sr_r[7:1] == sar_r[7:1]);
            rd_c  = sr_r[`SSP_RW_POS];
        end else if (!hi_ok_r) begin
            // high byte: marker plus A9..A8 against the stored pattern
            hit_c = (sr_r[7:3] == `SSP_TEN_MARK) &&
                    (sr_r[7:1] == sar_r[7:1]);
            if (sr_r[`SSP_RW_POS]) begin
                hit_c = hit_c && ten_hit_r;
                rd_c  = 1'b1;
            end else begin
                ua_c = 1'b1;
                hi_c = 1'b1;
            end
        end else begin
            hit_c = (sr_r == sar_r);
            ua_c  = 1'b1;
            ten_c = 1'b1;
        end
    end

    assign load_c = hit_c && !bf_r;
    assign ack_c  = load_c && !ov_r;

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r      <= ST_IDLE;
            after_r   <= ST_IDLE;
            sr_r      <= `SSP_BYTE_RST;
            cnt_r     <= 4'h0;
            in_addr_r <= 1'b1;
            hi_ok_r   <= 1'b0;
            ten_hit_r <= 1'b0;
            ack_r     <= 1'b0;
            ua_p_r    <= 1'b0;
            mack_r    <= 1'b0;
        end else begin
            if (!en || !slave_on(mode_select_field)) begin
                st_r      <= ST_IDLE;
                in_addr_r <= 1'b1;
                hi_ok_r   <= 1'b0;
                ten_hit_r <= 1'b0;
                ack_r     <= 1'b0;
            end else if (sta) begin
                st_r      <= ST_RX;
                cnt_r     <= 4'h0;
                in_addr_r <= 1'b1;
                hi_ok_r   <= 1'b0;
                ack_r     <= 1'b0;
            end else if (sto) begin
                st_r      <= ST_IDLE;
                ten_hit_r <= 1'b0;
                ack_r     <= 1'b0;
            end else begin
                case (st_r)
                    ST_RX: begin
                        if (scl_l.rise && cnt_r != `SSP_LAST_BIT) begin
                            sr_r  <= {sr_r[6:0], sda_l.lvl};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (done) begin
                            if (hit_c) begin
                                st_r      <= ST_ACK;
                                ack_r     <= ack_c;
                                ua_p_r    <= ua_c;
                                after_r   <= rd_c ? ST_TX : ST_RX;
                                in_addr_r <= hi_c;
                                hi_ok_r   <= hi_c;
                                ten_hit_r <= ten_hit_r || ten_c;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_l.fall) begin
                            st_r  <= after_r;
                            cnt_r <= 4'h0;
                            ack_r <= 1'b0;
                            if (after_r == ST_TX) begin
                                sr_r <= `SSP_TX_IDLE;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_l.fall) begin
                            if (cnt_r == `SSP_TX_LAST) begin
                                st_r <= ST_MACK;
                            end else begin
                                sr_r  <= {sr_r[6:0], 1'b1};
                                cnt_r <= cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_l.rise) begin
                            mack_r <= sda_l.lvl;
                        end else if (scl_l.fall) begin
                            cnt_r <= 4'h0;
                            if (mack_r) begin
                                st_r      <= ST_IDLE;
                                in_addr_r <= 1'b1;
                                ten_hit_r <= 1'b0;
                            end else begin
                                st_r <= ST_TX;
                                sr_r <= `SSP_TX_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
            // a buffer write also primes the shifter unless a byte is arriving
            if (buf_wr && st_r != ST_RX) begin
                sr_r <= buf_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // status flags; hardware set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bf_r  <= 1'b0;
            ov_r  <= 1'b0;
            irq_r <= 1'b0;
            ua_r  <= 1'b0;
        end else begin
            if (done && load_c) begin
                bf_r <= 1'b1;
            end else if (buf_rd) begin
                bf_r <= 1'b0;
            end
            if (done && hit_c && bf_r) begin
                ov_r <= 1'b1;
            end else if (ovf_clr) begin
                ov_r <= 1'b0;
            end
            if (nin_c || mk_c ||
                (en && sp_irq(mode_select_field) && (sta || sto))) begin
                irq_r <= 1'b1;
            end else if (irq_clr) begin
                irq_r <= 1'b0;
            end
            if (nin_c && ua_p_r) begin
                ua_r <= 1'b1;
            end else if (addr_wr) begin
                ua_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            buf_r <= `SSP_BYTE_RST;
            sar_r <= `SSP_BYTE_RST;
            ckp_r <= 1'b0;
            rw_r  <= 1'b0;
            da_r  <= 1'b0;
        end else begin
            if (done && load_c) begin
                buf_r <= sr_r;
            end else if (buf_wr) begin
                buf_r <= buf_wdata;
            end
            if (addr_wr) begin
                sar_r <= addr_wdata;
            end
            // a software write of the release bit overrides the hardware clear
            if (ckp_wr) begin
                ckp_r <= ckp_wdata;
            end else if (tx_go) begin
                ckp_r <= 1'b0;
            end
            if (done && hit_c && in_addr_r && !hi_ok_r) begin
                rw_r <= sr_r[`SSP_RW_POS];
            end
            if (done && hit_c) begin
                da_r <= !in_addr_r;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end else if (!en) begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end else if (sta) begin
            start_r <= 1'b1;
            stop_r  <= 1'b0;
        end else if (sto) begin
            start_r <= 1'b0;
            stop_r  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin drive: open drain, low only
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            pin_lo_r <= 1'b0;
        end else begin
            sda_oe_r <= en && ((st_r == ST_ACK && ack_r) ||
                               (st_r == ST_TX && !sr_r[7]));
            // stretch only once scl is low, else a false edge would appear
            scl_oe_r <= en && st_r != ST_IDLE &&
                        ((irq_r && !ckp_r) || ua_r) &&
                        (!scl_l.lvl || scl_oe_r);
        end
    end

    assign scl_out               = pin_lo_r;
    assign sda_out               = pin_lo_r;
    assign scl_oe                = scl_oe_r;
    assign sda_oe                = sda_oe_r;
    assign rx_tx_buffer          = buf_r;
    assign slave_address_reg     = sar_r;
    assign clock_release_bit     = ckp_r;
    assign buffer_full_flag      = bf_r;
    assign receive_overflow_flag = ov_r;
    assign update_address_flag   = ua_r;
    assign serial_port_irq_flag  = irq_r;
    assign rw_flag               = rw_r;
    assign data_flag             = da_r;
    assign start_flag            = start_r;
    assign stop_flag             = stop_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_full_ack;
        done && ack_c ##1 st_r == ST_ACK && ack_r;
    endsequence

    sequence s_stall;
        en && st_r != ST_IDLE && irq_r && !ckp_r && !scl_l.lvl && !ckp_wr;
    endsequence

    a_ack_drive: assert property (s_full_ack |=> sda_oe_r)
        else $error("acknowledge not driven after matched byte");
    a_ovf_block: assert property (done && hit_c && bf_r && !buf_wr
        |=> ov_r && !ack_r && $stable(buf_r))
        else $error("full buffer byte not refused");
    a_ovf_load: assert property (done && hit_c && !bf_r && ov_r
        |=> bf_r && !ack_r && buf_r == $past(sr_r))
        else $error("overflow-only byte handled wrongly");
    a_bf_clear: assert property (buf_rd && !(done && load_c) |=> !bf_r)
        else $error("buffer read did not clear full flag");
    a_ov_sticky: assert property (ov_r && !ovf_clr |=> ov_r)
        else $error("overflow flag cleared by hardware");
    a_irq_ninth: assert property (nin_c |=> irq_r)
        else $error("irq not set on ninth falling edge");
    a_scl_hold: assert property (s_stall ##1 s_stall |-> ##1 scl_oe_r)
        else $error("scl not held while irq set and release clear");
    a_ua_hold: assert property (ua_r && scl_oe_r && !addr_wr && en
        && st_r != ST_IDLE |=> scl_oe_r)
        else $error("scl released while update flag set");
    a_ua_clear: assert property (addr_wr && !(nin_c && ua_p_r) |=> !ua_r)
        else $error("address write did not clear update flag");
    a_nack_reset: assert property (mk_c && mack_r && en && !sta && !sto
        |=> st_r == ST_IDLE ##1 !sda_oe_r)
        else $error("nack did not reset slave logic");
    a_sp_clear: assert property (!en |=> !start_r && !stop_r)
        else $error("start or stop flag kept while disabled");
    a_idle_quiet: assert property (st_r == ST_IDLE |=> !sda_oe_r)
        else $error("sda driven while idle");

endmodule : ssp_i2c_slave

// File: verification/ssp_bus_mst.sv
/* behavioural two-wire bus master driving the slave under test.
   assumes tb_top resolves both lines open drain with pull-ups. */
`timescale 1ns/100ps
module ssp_bus_mst (
    input  wire logic clk_sys,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    // ------------------------------------------------------------
    // bus cycles, eight system clocks per high half bit, ten per low half
    // ------------------------------------------------------------
    initial {scl_low, sda_low} = 2'b00;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    // slave may stretch, so wait for scl high, bounded
    task automatic hi(output logic b);
        int k;
        scl_low <= 1'b0;
        for (k = 0; k < 3000 && scl !== 1'b1; k++) cyc(1);
        if (k == 3000) begin
            tb_top.n_fail++;
            tb_top.final_report();
        end
        b = sda;
        cyc(8);
    endtask : hi
    // s=1 start, s=0 stop; sda set up before scl rises, then moved while scl high
    task automatic cond(input logic s);
        logic b;
        sda_low <= !s;
        cyc(8);
        hi(b);
        sda_low <= s;
        cyc(8);
        scl_low <= s;
        cyc(2);
    endtask : cond
    // msb first then ack slot; mack=1 pulls sda for master ack
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] q, output logic ack);
        logic b;
        for (int i = 8; i >= 0; i--) begin
            sda_low <= (i == 0) ? mack : !d[i-1];
            cyc(8);
            hi(b);
            if (i > 0) q[i-1] = b;
            else ack = !b;
            scl_low <= 1'b1;
            cyc(2);
        end
        cyc(8);
    endtask : xbyte
endmodule : ssp_bus_mst

// File: verification/tb_top.sv
/* self-checking bench: model master plus software strobes.
   assumes core files and ssp_bus_mst compiled before it. */
`timescale 1ns/100ps
module tb_top;
    import ssp_pkg::*;
    // ------------------------------------------------------------
    // wiring, open drain with pull-ups
    // ------------------------------------------------------------
    logic       clk_sys, rst_b, port_enable_bit, ckp_wdata, ack, m_bf, m_ov, scl_low, sda_low;
    logic       buf_rd, buf_wr, addr_wr, ckp_wr, irq_clr, ovf_clr, scl_out, scl_oe, sda_out;
    logic       sda_oe, clock_release_bit, buffer_full_flag, receive_overflow_flag, rw_flag;
    logic       update_address_flag, serial_port_irq_flag, data_flag, start_flag, stop_flag;
    logic [3:0] mode_select_field;
    logic [7:0] buf_wdata, addr_wdata, rx_tx_buffer, slave_address_reg, q, d, m_buf;
    logic [6:0] a7;
    int         n_fail = 0, n_tests = 0, seed = 75;
    wire        scl = !(scl_oe || scl_low);
    wire        sda = !(sda_oe || sda_low);
    ssp_i2c_slave dut_u (.*, .scl_in(scl), .sda_in(sda));
    ssp_bus_mst   mst_u (.*);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = !clk_sys;
    end
    function automatic logic ack_exp(input logic bf, input logic ov);
        return !bf && !ov;
    endfunction : ack_exp
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // strobe bits: buf_rd buf_wr addr_wr ckp_wr irq_clr ovf_clr
    task automatic sw(input logic [5:0] s, input logic [7:0] v);
        @(posedge clk_sys);
        {buf_rd, buf_wr, addr_wr, ckp_wr, irq_clr, ovf_clr} <= s;
        {buf_wdata, addr_wdata, ckp_wdata} <= {v, v, v[0]};
        @(posedge clk_sys);
        {buf_rd, buf_wr, addr_wr, ckp_wr, irq_clr, ovf_clr} <= 6'h00;
        mst_u.cyc(2);
    endtask : sw
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        {rst_b, port_enable_bit, buf_rd, buf_wr, addr_wr, ckp_wr, irq_clr, ovf_clr} = 8'h00;
        {buf_wdata, addr_wdata, ckp_wdata} = 17'h0_0000;
        mode_select_field = SSP_M_S7;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        chk({1'b0, buffer_full_flag, serial_port_irq_flag, scl_oe, sda_oe, start_flag,
             receive_overflow_flag, clock_release_bit}, 8'h00);
        a7 = 7'($random(seed));
        // both seven-bit slave codes behave alike on the data path
        mode_select_field <= a7[0] ? SSP_M_MM7 : SSP_M_S7;
        port_enable_bit <= 1'b1;
        sw(6'h08, {a7, 1'b0});
        sw(6'h04, 8'h01);
        mst_u.cond(1'b1);
        chk({7'h00, start_flag}, 8'h01);
        mst_u.xbyte({a7 ^ 7'h01, 1'b0}, 1'b0, q, ack);
        chk({7'h00, ack}, 8'h00);
        mst_u.cond(1'b0);
        chk({7'h00, stop_flag}, 8'h01);
        mst_u.cond(1'b1);
        mst_u.xbyte({a7, 1'b0}, 1'b0, q, ack);
        chk({4'h0, ack, buffer_full_flag, rw_flag, serial_port_irq_flag}, 8'h0D);
        chk(rx_tx_buffer, {a7, 1'b0});
        {m_bf, m_ov} = 2'b00;
        sw(6'h22, 8'h00);
        chk({7'h00, buffer_full_flag}, 8'h00);
        // bf/ov cases in turn: clear, full, overflow only, clear again
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            mst_u.xbyte(d, 1'b0, q, ack);
            if (!m_bf) m_buf = d;
            chk({6'h00, ack, serial_port_irq_flag}, {6'h00, ack_exp(m_bf, m_ov), 1'b1});
            m_ov = m_ov | m_bf;
            m_bf = 1'b1;
            chk(rx_tx_buffer, m_buf);
            chk({6'h00, receive_overflow_flag, data_flag}, {6'h00, m_ov, 1'b1});
            sw((i == 0) ? 6'h02 : (6'h22 | {5'h00, i == 2}), 8'h00);
            m_bf = m_bf && i == 0;
            m_ov = m_ov && i != 2;
        end
        mst_u.cond(1'b0);
        $display("test write done");
        mst_u.cond(1'b1);
        mst_u.xbyte({a7, 1'b1}, 1'b0, q, ack);
        mst_u.cyc(4);
        chk({5'h00, ack, rw_flag, scl_oe}, 8'h07);
        d = 8'($random(seed));
        sw(6'h12, d);
        sw(6'h04, 8'h01);
        mst_u.xbyte(8'hFF, 1'b0, q, ack);
        chk(q, d);
        chk({7'h00, sda_oe}, 8'h00);
        mst_u.cond(1'b0);
        // firmware master code: slave idle, start still raises irq
        mode_select_field <= SSP_M_FWM;
        sw(6'h02, 8'h00);
        mst_u.cond(1'b1);
        mst_u.xbyte({a7, 1'b0}, 1'b0, q, ack);
        chk({5'h00, ack, serial_port_irq_flag, start_flag}, 8'h03);
        mst_u.cond(1'b0);
        port_enable_bit <= 1'b0;
        mst_u.cyc(4);
        chk({6'h00, start_flag, stop_flag}, 8'h00);
        $display("test read done");
        final_report();
    end
endmodule : tb_top
